/* hw/erd_pkg.sv */
/*
  constants for the external rampdown sequencer.
  assumes a 200 MHz system clock and fixed-point settings supplied by a host.
*/
package erd_pkg;
  localparam int CLK_MHZ = 200;
  localparam int TRIG_MIN_MS = 10;
  // sample interval kept well under the least closure time
  localparam int SAMPLE_US = 1000;
  localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
  // a closure must be seen on this many consecutive samples
  localparam int TRIG_SAMPLES = (TRIG_MIN_MS * 1000) / SAMPLE_US;
  localparam int HOLD_US = 100000;
  localparam int HOLD_CYC = HOLD_US * CLK_MHZ;
  localparam int CYC_PER_SEC = 1000000 * CLK_MHZ;
  // settings: seconds, millivolts, tenths of henry
  localparam logic [11:0] SW_TIME_MIN = 12'h005;
  localparam logic [11:0] SW_TIME_MAX = 12'hE10;
  localparam logic [11:0] SW_TIME_RST = 12'h014;
  localparam logic signed [15:0] VMIN_LO = -16'sd20000;
  localparam logic signed [15:0] VMIN_HI = 16'sd0;
  localparam logic signed [15:0] VMIN_RST = -16'sd6000;
  localparam logic signed [15:0] VMAX_LO = 16'sd1;
  localparam logic signed [15:0] VMAX_HI = 16'sd20000;
  localparam logic signed [15:0] VMAX_RST = 16'sd6000;
  localparam logic [13:0] IND_MAX = 14'h2710;
  localparam logic [13:0] IND_RST = 14'h0000;
  // which setting a write targets
  localparam logic [2:0] SEL_HEAT = 3'h0;
  localparam logic [2:0] SEL_COOL = 3'h1;
  localparam logic [2:0] SEL_VMIN = 3'h2;
  localparam logic [2:0] SEL_VMAX = 3'h3;
  localparam logic [2:0] SEL_IND = 3'h4;
  typedef enum logic [2:0] {
    ST_IDLE, ST_MATCH, ST_HOLD, ST_HEAT, ST_RAMPDN, ST_DONE, ST_QUENCH
  } erd_state_type;
endpackage

/* hw/erd_sequencer.sv */
/*
  external rampdown sequencer: contact trigger, persistent-mode handover,
  rampdown to zero, operator lockout and setting limit checks.
  assumes the supply loop reports matched and zero current as same-clock levels.
*/
`timescale 1ns/10ps
module erd_sequencer #(
  parameter int SAMPLE_CYC = erd_pkg::SAMPLE_CYC,
  parameter int HOLD_CYC = erd_pkg::HOLD_CYC,
  parameter int CYC_PER_SEC = erd_pkg::CYC_PER_SEC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // contact and enable
  input wire logic i_ext_contact,
  input wire logic i_ext_enable,
  // supply and magnet status
  input wire logic i_persistent,
  input wire logic i_current_matched,
  input wire logic i_current_zero,
  input wire logic i_quench,
  input wire logic i_quench_clear,
  // operator keys
  input wire logic i_key_enter,
  input wire logic i_key_other,
  // setting entry
  input wire logic i_set_wr,
  input wire logic [2:0] i_set_sel,
  input wire logic signed [15:0] i_set_val,
  // supply control
  output logic o_ramp_to_magnet,
  output logic o_ramp_down,
  output logic o_force_zero_volts,
  output logic o_superconducting_switch_heater,
  output logic o_at_target_indicator,
  output logic o_persistent_indicator,
  output logic o_ext_busy,
  output logic o_zero_current_mode,
  output logic o_key_pass,
  // settings and errors
  output logic o_beep,
  output logic o_set_error,
  output logic [11:0] o_heat_time,
  output logic [11:0] o_cool_time,
  output logic signed [15:0] o_vmin,
  output logic signed [15:0] o_vmax,
  output logic [13:0] o_inductance,
  output logic o_ind_unknown
);
  initial begin
    if (SAMPLE_CYC < 2 || HOLD_CYC < 1 || CYC_PER_SEC < 1) begin
      $error("erd_sequencer: bad timing parameters");
    end
  end

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [31:0] samp_cnt;
    logic [7:0] closed_cnt;
    logic trig;
    erd_pkg::erd_state_type st;
    logic [31:0] tmr;
    logic [11:0] secs;
    logic heater;
    logic at_tgt;
    logic pers_led;
    logic zero_mode;
    logic key_pass;
    logic beep;
    logic err;
    logic [11:0] heat_t;
    logic [11:0] cool_t;
    logic signed [15:0] vmin;
    logic signed [15:0] vmax;
    logic [13:0] ind;
    logic ramp_mag;
    logic ramp_dn;
    logic fzero;
    logic busy;
    logic ind_unk;
  } erd_regs_type;

  erd_regs_type s_r;
  erd_regs_type s_nxt;
  logic closed;
  logic ok;

  function automatic logic range_ok(input logic [2:0] sel, input logic signed [15:0] v);
    unique case (sel)
      erd_pkg::SEL_HEAT, erd_pkg::SEL_COOL: range_ok = v >= $signed({4'h0, erd_pkg::SW_TIME_MIN})
        && v <= $signed({4'h0, erd_pkg::SW_TIME_MAX});
      erd_pkg::SEL_VMIN: range_ok = v >= erd_pkg::VMIN_LO && v <= erd_pkg::VMIN_HI;
      erd_pkg::SEL_VMAX: range_ok = v >= erd_pkg::VMAX_LO && v <= erd_pkg::VMAX_HI;
      erd_pkg::SEL_IND: range_ok = v >= 16'sd0 && v <= $signed({2'h0, erd_pkg::IND_MAX});
      default: range_ok = 1'b0;
    endcase
  endfunction

  always_comb begin
    s_nxt = s_r;
    s_nxt.beep = 1'b0;
    s_nxt.err = 1'b0;
    s_nxt.trig = 1'b0;
    s_nxt.sync1 = i_ext_contact;
    s_nxt.sync2 = s_r.sync1;
    closed = s_r.sync2;
    ok = range_ok(i_set_sel, i_set_val);
    if (s_r.samp_cnt == 32'(SAMPLE_CYC - 1)) begin
      s_nxt.samp_cnt = 32'h0;
      if (closed && i_ext_enable) begin
        if (s_r.closed_cnt == 8'(erd_pkg::TRIG_SAMPLES - 1)) begin
          s_nxt.trig = 1'b1;
        end else begin
          s_nxt.closed_cnt = s_r.closed_cnt + 8'h1;
        end
      end else begin
        s_nxt.closed_cnt = 8'h0;
      end
    end else begin
      s_nxt.samp_cnt = s_r.samp_cnt + 32'h1;
    end
    s_nxt.pers_led = i_persistent;
    s_nxt.tmr = s_r.tmr + 32'h1;
    s_nxt.key_pass = (s_r.st == erd_pkg::ST_IDLE) && i_key_other;
    if (i_quench) begin
      s_nxt.st = erd_pkg::ST_QUENCH;
    end else begin
      unique case (s_r.st)
        erd_pkg::ST_IDLE: begin
          if (s_r.trig) begin
            s_nxt.zero_mode = 1'b0;
            s_nxt.tmr = 32'h0;
            if (i_persistent) s_nxt.heater = 1'b0;
            s_nxt.st = i_persistent ? erd_pkg::ST_MATCH : erd_pkg::ST_RAMPDN;
          end else if (i_set_wr) begin
            if (!ok) begin
              s_nxt.beep = 1'b1;
              s_nxt.err = 1'b1;
            end else begin
              if (i_set_sel == erd_pkg::SEL_HEAT) s_nxt.heat_t = i_set_val[11:0];
              if (i_set_sel == erd_pkg::SEL_COOL) s_nxt.cool_t = i_set_val[11:0];
              if (i_set_sel == erd_pkg::SEL_VMIN) s_nxt.vmin = i_set_val;
              if (i_set_sel == erd_pkg::SEL_VMAX) s_nxt.vmax = i_set_val;
              if (i_set_sel == erd_pkg::SEL_IND) s_nxt.ind = i_set_val[13:0];
            end
          end
        end
        erd_pkg::ST_MATCH: begin
          if (i_current_matched) begin
            s_nxt.at_tgt = 1'b1;
            s_nxt.tmr = 32'h0;
            s_nxt.st = erd_pkg::ST_HOLD;
          end
        end
        erd_pkg::ST_HOLD: begin
          if (s_r.tmr >= 32'(HOLD_CYC - 1)) begin
            s_nxt.heater = 1'b1;
            s_nxt.tmr = 32'h0;
            s_nxt.secs = 12'h0;
            s_nxt.st = erd_pkg::ST_HEAT;
          end
        end
        erd_pkg::ST_HEAT: begin
          if (s_r.tmr >= 32'(CYC_PER_SEC - 1)) begin
            s_nxt.tmr = 32'h0;
            s_nxt.secs = s_r.secs + 12'h1;
          end
          if (s_r.secs >= s_r.heat_t) begin
            s_nxt.at_tgt = 1'b0;
            s_nxt.st = erd_pkg::ST_RAMPDN;
          end
        end
        erd_pkg::ST_RAMPDN: begin
          s_nxt.at_tgt = 1'b0;
          if (i_current_zero) s_nxt.st = erd_pkg::ST_DONE;
        end
        erd_pkg::ST_DONE: begin
          if (i_key_enter && !closed) begin
            s_nxt.zero_mode = 1'b1;
            s_nxt.closed_cnt = 8'h0;
            s_nxt.st = erd_pkg::ST_IDLE;
          end
        end
        erd_pkg::ST_QUENCH: begin
          if (i_quench_clear) s_nxt.st = erd_pkg::ST_IDLE;
        end
        default: s_nxt.st = erd_pkg::ST_IDLE;
      endcase
    end
    if (s_nxt.pers_led && s_nxt.st == erd_pkg::ST_RAMPDN) s_nxt.pers_led = 1'b0;
    s_nxt.ramp_mag = (s_nxt.st == erd_pkg::ST_MATCH);
    s_nxt.ramp_dn = (s_nxt.st == erd_pkg::ST_RAMPDN);
    s_nxt.fzero = (s_nxt.st == erd_pkg::ST_QUENCH);
    s_nxt.busy = (s_nxt.st != erd_pkg::ST_IDLE) && (s_nxt.st != erd_pkg::ST_QUENCH);
    s_nxt.ind_unk = (s_nxt.ind == 14'h0);
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_r <= '0;
      s_r.st <= erd_pkg::ST_IDLE;
      s_r.heat_t <= erd_pkg::SW_TIME_RST;
      s_r.cool_t <= erd_pkg::SW_TIME_RST;
      s_r.vmin <= erd_pkg::VMIN_RST;
      s_r.vmax <= erd_pkg::VMAX_RST;
      s_r.ind <= erd_pkg::IND_RST;
      s_r.ind_unk <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_ramp_to_magnet = s_r.ramp_mag;
  assign o_ramp_down = s_r.ramp_dn;
  assign o_force_zero_volts = s_r.fzero;
  assign o_ext_busy = s_r.busy;
  assign o_superconducting_switch_heater = s_r.heater;
  assign o_at_target_indicator = s_r.at_tgt;
  assign o_persistent_indicator = s_r.pers_led;
  assign o_zero_current_mode = s_r.zero_mode;
  assign o_key_pass = s_r.key_pass;
  assign o_beep = s_r.beep;
  assign o_set_error = s_r.err;
  assign o_heat_time = s_r.heat_t;
  assign o_cool_time = s_r.cool_t;
  assign o_vmin = s_r.vmin;
  assign o_vmax = s_r.vmax;
  assign o_inductance = s_r.ind;
  assign o_ind_unknown = s_r.ind_unk;

  property p_lockout;
    @(posedge i_clk) disable iff (i_sys_rst)
      o_ext_busy |=> !o_key_pass;
  endproperty
  a_lockout: assert property (p_lockout) else $error("key passed while busy");

  property p_match_off;
    @(posedge i_clk) disable iff (i_sys_rst)
      o_ramp_to_magnet |-> !o_superconducting_switch_heater;
  endproperty
  a_match_off: assert property (p_match_off) else $error("heater on in match");

  property p_hold;
    @(posedge i_clk) disable iff (i_sys_rst)
      o_ramp_to_magnet && i_current_matched && !i_quench |=> o_at_target_indicator;
  endproperty
  a_hold: assert property (p_hold) else $error("at-target not lit");

  property p_rdn;
    @(posedge i_clk) disable iff (i_sys_rst)
      o_ramp_down ##1 o_ramp_down |-> !o_at_target_indicator && !o_persistent_indicator;
  endproperty
  a_rdn: assert property (p_rdn) else $error("indicator lit in rampdown");

  property p_done;
    @(posedge i_clk) disable iff (i_sys_rst)
      (s_r.st == erd_pkg::ST_DONE) && closed && !i_quench |=> s_r.st == erd_pkg::ST_DONE;
  endproperty
  a_done: assert property (p_done) else $error("left done while closed");

  property p_bad;
    @(posedge i_clk) disable iff (i_sys_rst)
      i_set_wr && !ok && s_r.st == erd_pkg::ST_IDLE && !s_r.trig && !i_quench
        |=> o_beep && o_set_error && $stable(o_heat_time) && $stable(o_vmax);
  endproperty
  a_bad: assert property (p_bad) else $error("bad entry not refused");

  property p_quench;
    @(posedge i_clk) disable iff (i_sys_rst)
      i_quench |=> o_force_zero_volts;
  endproperty
  a_quench: assert property (p_quench) else $error("quench not zeroed");

  property p_enable;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_r.trig |-> $past(i_ext_enable);
  endproperty
  a_enable: assert property (p_enable) else $error("trigger while disabled");
endmodule

/* tb/erd_contact_model.sv */
/*
  dry contact pair on the far side of the rampdown input.
  assumes the bench commands closures on the falling clock edge.
*/
`timescale 1ns/10ps
module erd_contact_model #(
  parameter int MIN_CYC = 48
) (
  // commands
  input wire logic i_clk,
  input wire logic i_close,
  input wire logic i_short,
  // contact, closed is 1
  output logic o_contact
);
  int hold_cnt = 0;
  always_ff @(posedge i_clk) begin
    if (i_close) hold_cnt <= MIN_CYC;
    else if (hold_cnt > 0) hold_cnt <= hold_cnt - 1;
  end
  // short closure only on command
  assign o_contact = i_close | i_short | (hold_cnt > 0);
endmodule

/* tb/erd_sequencer_tb_top.sv */
/*
  self-checking bench for the rampdown sequencer.
  assumes shortened counts: sample 4, hold 3, 5 cycles a second.
*/
`timescale 1ns/10ps
module erd_sequencer_tb_top;
  logic i_clk, i_sys_rst, i_ext_enable, i_persistent, i_current_matched;
  logic i_current_zero, i_quench, i_quench_clear, i_key_enter, i_key_other;
  logic i_set_wr, i_close, i_short;
  logic [2:0] i_set_sel;
  logic signed [15:0] i_set_val, o_vmin, o_vmax;
  wire logic i_ext_contact;
  logic o_ramp_to_magnet, o_ramp_down, o_force_zero_volts, o_ext_busy;
  logic o_superconducting_switch_heater, o_at_target_indicator;
  logic o_persistent_indicator, o_zero_current_mode, o_key_pass;
  logic o_beep, o_set_error, o_ind_unknown;
  logic [11:0] o_heat_time, o_cool_time;
  logic [13:0] o_inductance;
  int failures = 0;
  int cmp_count = 0;

  erd_sequencer #(.SAMPLE_CYC(4), .HOLD_CYC(3), .CYC_PER_SEC(5)) uut (
    .i_clk, .i_sys_rst, .i_ext_contact, .i_ext_enable, .i_persistent,
    .i_current_matched, .i_current_zero, .i_quench, .i_quench_clear,
    .i_key_enter, .i_key_other, .i_set_wr, .i_set_sel, .i_set_val,
    .o_ramp_to_magnet, .o_ramp_down, .o_force_zero_volts,
    .o_superconducting_switch_heater, .o_at_target_indicator,
    .o_persistent_indicator, .o_ext_busy, .o_zero_current_mode, .o_key_pass,
    .o_beep, .o_set_error, .o_heat_time, .o_cool_time, .o_vmin, .o_vmax,
    .o_inductance, .o_ind_unknown
  );
  erd_contact_model #(.MIN_CYC(48)) partner (
    .i_clk, .i_close, .i_short, .o_contact(i_ext_contact)
  );

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic end_of_test;
    if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [18:0] sv, input logic bad);
    logic b;
    b = 1'b0;
    {i_set_sel, i_set_val} = sv;
    i_set_wr = 1'b1;
    @(negedge i_clk) i_set_wr = 1'b0;
    b = o_beep & o_set_error;
    repeat (3) @(negedge i_clk) b = b | (o_beep & o_set_error);
    chk(b, bad);
  endtask

  task automatic enter_press;
    i_key_enter = 1'b1;
    @(negedge i_clk) i_key_enter = 1'b0;
    repeat (2) @(negedge i_clk);
  endtask

  task automatic t_reset;
    chk(o_heat_time, 16'h0014);
    chk(o_cool_time, 16'h0014);
    chk(o_vmin, 16'hE890);
    chk(o_vmax, 16'h1770);
    chk(o_inductance, 16'h0000);
    chk(o_ind_unknown, 16'h0001);
  endtask

  task automatic t_settings;
    logic [18:0] bad_t [10] = '{19'h00004, 19'h00E11, 19'h10004, 19'h10E11,
      19'h20001, 19'h2B1DF, 19'h30000, 19'h34E21, 19'h42711, 19'h50000};
    foreach (bad_t[k]) wr(bad_t[k], 1'b1);
    t_reset();
    wr(19'h00005, 1'b0);
    wr(19'h10E10, 1'b0);
    wr(19'h2B1E0, 1'b0);
    wr(19'h30001, 1'b0);
    wr(19'h42710, 1'b0);
    chk(o_heat_time, 16'h0005);
    chk(o_cool_time, 16'h0E10);
    chk(o_vmin, 16'hB1E0);
    chk(o_vmax, 16'h0001);
    chk({o_ind_unknown, o_inductance}, 16'h2710);
    wr(19'h40000, 1'b0);
    chk(o_ind_unknown, 16'h0001);
  endtask

  task automatic t_notrig;
    i_ext_enable = 1'b0;
    i_close = 1'b1;
    @(negedge i_clk) i_close = 1'b0;
    repeat (80) @(negedge i_clk);
    chk(o_ext_busy, 16'h0000);
    i_ext_enable = 1'b1;
    i_short = 1'b1;
    repeat (12) @(negedge i_clk);
    i_short = 1'b0;
    repeat (60) @(negedge i_clk);
    chk(o_ext_busy, 16'h0000);
  endtask

  task automatic t_persist;
    int n;
    i_persistent = 1'b1;
    i_key_other = 1'b1;
    @(negedge i_clk) i_key_other = 1'b0;
    chk(o_key_pass, 16'h0001);
    i_close = 1'b1;
    for (n = 0; n < 200 && o_ramp_to_magnet !== 1'b1; n++) @(negedge i_clk);
    chk(o_ramp_to_magnet, 16'h0001);
    chk(o_superconducting_switch_heater, 16'h0000);
    i_key_other = 1'b1;
    @(negedge i_clk) i_key_other = 1'b0;
    chk(o_key_pass, 16'h0000);
    repeat (5) @(negedge i_clk);
    chk(o_at_target_indicator, 16'h0000);
    i_current_matched = 1'b1;
    repeat (2) @(negedge i_clk);
    chk(o_at_target_indicator, 16'h0001);
    chk(o_superconducting_switch_heater, 16'h0000);
    for (n = 0; n < 10 && o_superconducting_switch_heater !== 1'b1; n++) @(negedge i_clk);
    chk(o_superconducting_switch_heater, 16'h0001);
    i_current_matched = 1'b0;
    repeat (20) @(negedge i_clk);
    chk(o_ramp_down, 16'h0000);
    for (n = 0; n < 15 && o_ramp_down !== 1'b1; n++) @(negedge i_clk);
    chk(o_ramp_down, 16'h0001);
    chk(o_at_target_indicator, 16'h0000);
    chk(o_persistent_indicator, 16'h0000);
    i_current_zero = 1'b1;
    repeat (3) @(negedge i_clk);
    enter_press();
    chk(o_zero_current_mode, 16'h0000);
    chk(o_ext_busy, 16'h0001);
    i_close = 1'b0;
    repeat (70) @(negedge i_clk);
    enter_press();
    chk(o_zero_current_mode, 16'h0001);
    chk(o_superconducting_switch_heater, 16'h0001);
    chk(o_ext_busy, 16'h0000);
    i_current_zero = 1'b0;
    i_persistent = 1'b0;
  endtask

  task automatic t_nonpersist;
    int n;
    i_close = 1'b1;
    for (n = 0; n < 200 && o_ext_busy !== 1'b1; n++) @(negedge i_clk);
    repeat (2) @(negedge i_clk);
    chk(o_ramp_down, 16'h0001);
    chk(o_ramp_to_magnet, 16'h0000);
    i_key_other = 1'b1;
    @(negedge i_clk) i_key_other = 1'b0;
    chk(o_key_pass, 16'h0000);
    chk(o_ramp_down, 16'h0001);
    i_quench = 1'b1;
    repeat (2) @(negedge i_clk);
    chk(o_force_zero_volts, 16'h0001);
    {i_quench, i_close, i_quench_clear} = 3'h1;
    @(negedge i_clk) i_quench_clear = 1'b0;
    repeat (70) @(negedge i_clk);
    chk(o_force_zero_volts, 16'h0000);
  endtask

  initial begin
    {i_sys_rst, i_ext_enable, i_persistent, i_current_matched} = 4'h8;
    {i_current_zero, i_quench, i_quench_clear, i_key_enter} = 4'h0;
    {i_key_other, i_set_wr, i_close, i_short} = 4'h0;
    i_set_sel = 3'h0;
    i_set_val = 16'h0000;
    repeat (6) @(negedge i_clk);
    i_sys_rst = 1'b0;
    @(negedge i_clk);
    t_reset();
    t_settings();
    t_notrig();
    t_persist();
    t_nonpersist();
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    end_of_test();
  end
endmodule
